// ---- inc/sfp_map.svh ----
// Constants for the pause/data-line-three block of a serial flash.
// Assumes MCLK at 20 MHz and SPI pins from an external host.
// Notes on behaviour
// - While paused, ignore clock edges and input data; float output; keep selection.
// - Pause halts only serial transfer; internal program or erase keeps running.
// - Quad page program: capture four bits on lines three to zero each rising edge.
// - Quad read: drive four lines, new nibble on every falling clock edge.
// - Quad enable clear: line three is pause or reset per status-three bit 7.
// - Quad enable set: no pause or reset function on line three.
// - Quad enable bit in status two turns lines two and three into data lines.
// - Input latched on rising clock edge, output shifted on falling edge.
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH
`define SFP_SR2_QE_BIT    1
`define SFP_SR3_FSEL_BIT  7
`define SFP_SR_RESET      8'h00
`define SFP_MODE_QIN      2'h1
`define SFP_MODE_QOUT     2'h2
`define SFP_NIBBLE_RESET  4'h0
`define SFP_CS_IDLE       2'h3
`define SFP_SCK_IDLE      2'h0
`define SFP_DQ_IDLE       4'hF
`endif

// ---- inc/sfp_pkg.sv ----
// Types for the pause/data-line-three block.
// Assumes sfp_map.svh provides the numeric constants.
package sfp_pkg;
  typedef enum logic [1:0] {SFP_IDLE = 2'b00, SFP_ACTIVE = 2'b01, SFP_PAUSED = 2'b11} sfp_state_t;
  typedef struct packed {
    logic       oe_n;
    logic [3:0] data;
  } sfp_quad_out_t;
endpackage : sfp_pkg

// ---- rtl/sfp_line3.sv ----
// Fourth data line handling: pause/reset input or quad data line.
// Assumes serial pins are asynchronous to MCLK and sampled well above the SPI rate.
`timescale 1ns/1ps
`include "sfp_map.svh"
module sfp_line3
  import sfp_pkg::*;
(
  input  wire logic       MCLK,
  input  wire logic       SYS_RST,
  input  wire logic       CS_N,
  input  wire logic       SCK,
  input  wire logic [3:0] DQ_IN,
  output logic      [3:0] DQ_OUT,
  output logic      [3:0] DQ_OE_N,
  input  wire logic [7:0] STATUS2,
  input  wire logic [7:0] STATUS3,
  input  wire logic [1:0] QUAD_MODE,
  input  wire logic [3:0] TX_NIBBLE,
  input  wire logic       TX_SERIAL_BIT,
  input  wire logic       TX_SERIAL_EN,
  input  wire logic       INTERNAL_BUSY,
  output logic            SHIFT_IN,
  output logic            SHIFT_OUT,
  output logic      [3:0] RX_NIBBLE,
  output logic            PAUSED,
  output logic            PIN_RESET,
  output logic            BUSY_OUT
);
  logic [1:0] cs_s;
  logic [1:0] sck_s;
  logic [3:0] dq_s0;
  logic [3:0] dq_s1;
  logic       sck_d;
  sfp_state_t state;
  sfp_quad_out_t qo;

  // Select and clock are plain levels from the host; two flops each keep
  // metastability out of the state machine, and only the second is read
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      cs_s <= `SFP_CS_IDLE;
    else
      cs_s <= {cs_s[0], CS_N};
  end

  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      sck_s <= `SFP_SCK_IDLE;
    else
      sck_s <= {sck_s[0], SCK};
  end

  // Data lines: the first stage feeds nothing but the second stage
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      dq_s0 <= `SFP_DQ_IDLE;
    else
      dq_s0 <= DQ_IN;
  end

  // Idle level is high, matching the pulled-up lines, so no false pause
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      dq_s1 <= `SFP_DQ_IDLE;
    else
      dq_s1 <= dq_s0;
  end

  // Quad page program decode: all four lines are inputs
  function automatic logic quad_in_sel
  (
    input logic       qe,
    input logic [1:0] mode
  );
    return qe && (mode == `SFP_MODE_QIN);
  endfunction : quad_in_sel

  // Quad read decode: all four lines are outputs
  function automatic logic quad_out_sel
  (
    input logic       qe,
    input logic [1:0] mode
  );
    return qe && (mode == `SFP_MODE_QOUT);
  endfunction : quad_out_sel

  // Single-line output word: only the serial output line carries the bit
  function automatic logic [3:0] serial_word
  (
    input logic b
  );
    return {2'h0, b, 1'b0};
  endfunction : serial_word

  // Single-line input word: only line zero is captured
  function automatic logic [3:0] serial_capture
  (
    input logic [3:0] d
  );
    return {3'h0, d[0]};
  endfunction : serial_capture

  logic quad_en;
  logic line3_low;
  assign quad_en   = STATUS2[`SFP_SR2_QE_BIT];
  assign line3_low = !quad_en && !dq_s1[3];

  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      sck_d <= 1'b0;
    else
      sck_d <= sck_s[1];
  end

  logic pause_req;
  assign pause_req = line3_low && !STATUS3[`SFP_SR3_FSEL_BIT];
  assign PIN_RESET = line3_low && STATUS3[`SFP_SR3_FSEL_BIT];
  // Internal program/erase is never gated by the pause
  assign BUSY_OUT  = INTERNAL_BUSY;

  // Pause begins only with select low and clock low, held across the wait
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      state <= SFP_IDLE;
    else
      case (state)
        SFP_IDLE:
        begin
          // A frame opens on the synchronised select edge
          if (!cs_s[1])
            state <= SFP_ACTIVE;
        end
        SFP_ACTIVE:
        begin
          if (cs_s[1])
            state <= SFP_IDLE;
          else if (pause_req && !sck_s[1])
            state <= SFP_PAUSED;
        end
        SFP_PAUSED:
        begin
          // Select is not dropped by a pause; RX_NIBBLE is held, not cleared
          if (!pause_req)
            state <= cs_s[1] ? SFP_IDLE : SFP_ACTIVE;
        end
        default:    state <= SFP_IDLE;
      endcase
  end

  logic pause_start;
  logic pause_hold;
  logic pause_now;
  logic live;
  // A pause may only begin inside a frame with the clock low
  assign pause_start = (state == SFP_ACTIVE) && pause_req && !sck_s[1];
  // Releasing the line ends the pause at once, so a quad enable or function
  // change can never leave a stale pause showing
  assign pause_hold  = (state == SFP_PAUSED) && pause_req;
  assign pause_now   = pause_start || pause_hold;
  // The exit cycle of a pause is live, so an edge landing there is not lost
  assign live        = (state != SFP_IDLE) && !cs_s[1] && !pause_now;
  // Clock edges during pause are dropped so the bit position is kept
  assign SHIFT_IN  = live && sck_s[1] && !sck_d;
  assign SHIFT_OUT = live && !sck_s[1] && sck_d;
  assign PAUSED    = pause_hold;

  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      RX_NIBBLE <= `SFP_NIBBLE_RESET;
    else if (SHIFT_IN)
      RX_NIBBLE <= quad_in_sel(quad_en, QUAD_MODE) ? dq_s1 : serial_capture(dq_s1);
  end

  // Output enables go low only while driving. A pause does not clear the
  // held enable: the float is applied at the pins, so the paused bit is
  // driven again as soon as the pause ends
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      qo <= '{oe_n: 1'b1, data: `SFP_NIBBLE_RESET};
    else if (cs_s[1])
      qo.oe_n <= 1'b1;
    else if (SHIFT_OUT)
    begin
      if (quad_out_sel(quad_en, QUAD_MODE))
      begin
        qo.data <= TX_NIBBLE;
        qo.oe_n <= 1'b0;
      end
      else
      begin
        qo.data <= serial_word(TX_SERIAL_BIT);
        qo.oe_n <= !TX_SERIAL_EN;
      end
    end
  end

  logic quad_drive;
  logic oe_n_eff;
  assign quad_drive = quad_out_sel(quad_en, QUAD_MODE);
  // Every line floats while paused
  assign oe_n_eff   = qo.oe_n || PAUSED;
  assign DQ_OUT     = qo.data;
  assign DQ_OE_N    = quad_drive ? {4{oe_n_eff}} : {2'h3, oe_n_eff, 1'b1};
endmodule : sfp_line3

// ---- tb/sfp_host.sv ----
// Host model on the serial pins, mode 0; assumes calls just after MCLK edges.
`timescale 1ns/1ps
module sfp_host (
  input wire logic MCLK,
  output logic CS_N = 1'h1,
  output logic SCK = 1'h0,
  output logic [3:0] HDQ = 4'hF
);
  // Lines move only with SCK low, so a pause never starts inside a pulse
  task automatic bit_cyc(input logic [3:0] d);
    CS_N <= 1'h0;
    HDQ <= d;
    repeat (4) @(posedge MCLK);
    SCK <= 1'h1;
    repeat (4) @(posedge MCLK);
    SCK <= 1'h0;
    repeat (5) @(posedge MCLK);
  endtask : bit_cyc
endmodule : sfp_host

// ---- tb/sfp_line3_chk.sv ----
// Checker on sfp_line3 ports; assumes the bind below.
`timescale 1ns/1ps
module sfp_line3_chk (
  input wire logic MCLK, SYS_RST, SHIFT_IN, SHIFT_OUT, PAUSED, PIN_RESET, BUSY_OUT,
  input wire logic INTERNAL_BUSY, TX_SERIAL_BIT, TX_SERIAL_EN,
  input wire logic [7:0] STATUS2, STATUS3,
  input wire logic [1:0] QUAD_MODE,
  input wire logic [3:0] DQ_IN, DQ_OUT, DQ_OE_N, TX_NIBBLE, RX_NIBBLE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  no_shift_a: assert property (PAUSED |-> !SHIFT_IN && !SHIFT_OUT) else $error("shift");
  pause_float_a: assert property (PAUSED |-> &DQ_OE_N) else $error("drive");
  busy_pass_a: assert property (BUSY_OUT == INTERNAL_BUSY) else $error("busy");
  quad_in_a: assert property (SHIFT_IN && STATUS2[1] && QUAD_MODE == 2'h1 |=>
    RX_NIBBLE == $past(DQ_IN, 3)) else $error("rx");
  quad_out_a: assert property (SHIFT_OUT && STATUS2[1] && QUAD_MODE == 2'h2 |=>
    DQ_OUT == $past(TX_NIBBLE) && !DQ_OE_N) else $error("tx");
  serial_out_a: assert property (SHIFT_OUT && !STATUS2[1] |=>
    DQ_OUT[1] == $past(TX_SERIAL_BIT) && DQ_OE_N[1] == !$past(TX_SERIAL_EN)) else $error("so");
  qe_data_a: assert property (STATUS2[1] |-> !PAUSED && !PIN_RESET) else $error("qe");
  reset_sel_a: assert property (PIN_RESET |-> STATUS3[7]) else $error("sel");
  pause_sel_a: assert property (PAUSED |-> !STATUS3[7]) else $error("sel");
endmodule : sfp_line3_chk
bind sfp_line3 sfp_line3_chk i_sfp_line3_chk (.*);

// ---- tb/tb_top.sv ----
// Bench: host model on the pins; assumes a 50 ns MCLK.
`timescale 1ns/1ps
module tb_top;
  logic MCLK = 1'h0, SYS_RST = 1'h1, INTERNAL_BUSY = 1'h0, TX_SERIAL_BIT = 1'h0;
  logic TX_SERIAL_EN = 1'h0, CS_N, SCK, SHIFT_IN, SHIFT_OUT, PAUSED, PIN_RESET, BUSY_OUT;
  logic [7:0] STATUS2 = 8'h00, STATUS3 = 8'h00;
  logic [1:0] QUAD_MODE = 2'h0;
  logic [3:0] TX_NIBBLE = 4'h0, HDQ, DQ_IN, DQ_OUT, DQ_OE_N, RX_NIBBLE;
  int n_errors = 0, total_checks = 0, cyc = 0, n_in = 0, c;
  assign DQ_IN = ~DQ_OE_N & DQ_OUT | DQ_OE_N & HDQ;
  sfp_host i_sfp_host (.*);
  sfp_line3 i_sfp_line3 (.*);
  always #25 MCLK = ~MCLK;
  always @(posedge MCLK)
  begin
    n_in += SHIFT_IN;
    if (++cyc > 500)
    begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [3:0] e, a);
    total_checks++;
    if (a !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %0t %h %h", $time, e, a);
    end
  endtask : chk
  task automatic end_of_test;
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic t_pause;
    INTERNAL_BUSY <= 1'h1;
    i_sfp_host.bit_cyc(4'h8);
    c = n_in;
    i_sfp_host.bit_cyc(4'h0);
    chk(4'hF, DQ_OE_N);
    chk(4'h3, {2'h0, PAUSED, BUSY_OUT});
    i_sfp_host.bit_cyc(4'h8);
    chk(4'h1, 4'(n_in - c));
    STATUS3 <= 8'h80;
    i_sfp_host.bit_cyc(4'h0);
    chk(4'h2, {2'h0, PIN_RESET, PAUSED});
  endtask : t_pause
  task automatic t_quad;
    STATUS2 <= 8'h02;
    QUAD_MODE <= 2'h1;
    i_sfp_host.bit_cyc(4'h3);
    chk(4'h3, RX_NIBBLE);
    chk(4'h0, {PAUSED, PIN_RESET, 2'h0});
    QUAD_MODE <= 2'h2;
    TX_NIBBLE <= 4'h9;
    // Released lines: pull-ups high, others carry the last nibble
    i_sfp_host.bit_cyc(4'hC);
    chk(4'h9, DQ_OUT | DQ_OE_N);
  endtask : t_quad
  task automatic t_serial;
    STATUS2 <= 8'h00;
    STATUS3 <= 8'h00;
    QUAD_MODE <= 2'h0;
    TX_SERIAL_BIT <= 1'h1;
    TX_SERIAL_EN <= 1'h1;
    i_sfp_host.bit_cyc(4'h8);
    chk(4'hD, DQ_OE_N);
    chk(4'h2, DQ_OUT);
    i_sfp_host.bit_cyc(4'h0);
    chk(4'hF, DQ_OE_N);
    i_sfp_host.bit_cyc(4'h8);
    chk(4'hD, DQ_OE_N);
  endtask : t_serial
  initial
  begin
    repeat (12) @(posedge MCLK);
    SYS_RST <= 1'h0;
    t_pause();
    t_quad();
    t_serial();
    end_of_test();
  end
endmodule : tb_top
